// file: include/slave_dma_regs.svh
// register offsets, field positions, reset values and sizes of the DMA block
`ifndef SLAVE_DMA_REGS_SVH
`define SLAVE_DMA_REGS_SVH

`define ADDR_W 12
`define HW_MODE_ADDR 12'h300
`define DMA_CFG_ADDR 12'h330
`define DMA_STATUS_ADDR 12'h3F0

`define CFG_COUNT_MSB 31
`define CFG_COUNT_LSB 8
`define CFG_RSVD_MSB 7
`define CFG_RSVD_LSB 4
`define CFG_BURST_MSB 3
`define CFG_BURST_LSB 2
`define CFG_RUN_BIT 1
`define CFG_DIR_BIT 0

`define HW_REQ_POL_BIT 5
`define HW_BUS32_BIT 8

`define DMA_CFG_RESET 32'h0000_0000
`define HW_MODE_RESET 32'h0000_0000
`define REQ_PIN_RESET 1'b1

`define FIFO_DEPTH 4
`define FIFO_AW 2
`define DATA_W 32

`endif

// file: include/slave_dma_pkg.sv
// types shared by the slave DMA block
package slave_dma_pkg;

    typedef enum logic [1:0] {
        BURST_SINGLE = 2'b00,
        BURST_4 = 2'b01,
        BURST_8 = 2'b10,
        BURST_16 = 2'b11
    } burst_cycle_select_t;

    typedef enum logic {
        DIR_INTO_RAM = 1'b0,
        DIR_FROM_RAM = 1'b1
    } dma_dir_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_GAP = 2'b10,
        ST_DRAIN = 2'b11
    } dma_state_t;

    typedef struct packed {
        logic [23:0] byte_count;
        burst_cycle_select_t burst_cycle_select;
        logic run;
        dma_dir_t dir;
    } dma_cfg_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_bus_t;

endpackage

// file: src/dma_fifo.sv
// small fifo with registered ready, valid and data outputs between external bus and internal ram
`timescale 1ns/1ns
module dma_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    // fill level after this cycle
    output logic [AW:0] level_next
);
    // pointers wrap naturally, so depth must be a power of two
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] wr_ptr_next;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW-1:0] rd_ptr_next;
    logic [AW:0] count_reg;
    logic in_ready_reg;
    logic out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    wire push = in_valid && in_ready_reg;
    wire pop = out_ready && out_valid_reg;
    wire [AW:0] depth_c = (AW+1)'(DEPTH);

    assign wr_ptr_next = flush ? '0 : (push ? wr_ptr_reg + 1'b1 : wr_ptr_reg);
    assign rd_ptr_next = flush ? '0 : (pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg);
    assign level_next = flush ? '0 :
        (push && !pop) ? count_reg + 1'b1 :
        (pop && !push) ? count_reg - 1'b1 : count_reg;

    assign in_ready = in_ready_reg;
    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // head word is prefetched so the drain side sees a flop, not the array
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready_reg <= 1'b0;
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= level_next;
            in_ready_reg <= level_next != depth_c;
            out_valid_reg <= level_next != '0;
            if (push && wr_ptr_reg == rd_ptr_next) begin
                out_data_reg <= in_data;
            end else begin
                out_data_reg <= mem[rd_ptr_next];
            end
        end
    end
endmodule

// file: src/host_slave_dma_config.sv
// slave DMA channel: configuration register, burst engine and data path
// Summary of operation
// - 24-bit byte count held in bits 31:8
// - bursts derived from byte count and bus width
// - bits 3:2 pick single, 4, 8, 16 cycles
// - bit 0 picks write into or read from ram
// - request pin polarity follows mode bit 5
//
// Strobed register access was decided locally.
`include "slave_dma_regs.svh"
`timescale 1ns/1ns
module host_slave_dma_config (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire slave_dma_pkg::reg_bus_t bus,
    output logic [31:0] rd_data,
    // external dma controller pins
    output logic transfer_request_pin,
    input wire logic dma_ack_pin,
    input wire logic [31:0] ext_data_in,
    output logic [31:0] ext_data_out,
    output logic ext_data_oe,
    // internal ram, write stream
    output logic ram_wr_valid,
    output logic [31:0] ram_wr_data,
    input wire logic ram_wr_ready,
    // internal ram, read stream
    input wire logic ram_rd_valid,
    input wire logic [31:0] ram_rd_data,
    output logic ram_rd_ready
);
    import slave_dma_pkg::*;

    // rounded-up division by a power of two
    function automatic logic [24:0] ceil_shift(input logic [24:0] value,
                                               input logic [2:0] sh);
        logic [25:0] sum;
        sum = {1'b0, value} + ((26'h1 << sh) - 26'h1);
        return 25'(sum >> sh);
    endfunction

    // log2 of the beats in one burst
    function automatic logic [2:0] burst_shift(input burst_cycle_select_t s);
        case (s)
            BURST_SINGLE: return 3'h0;
            BURST_4: return 3'h2;
            BURST_8: return 3'h3;
            BURST_16: return 3'h4;
            default: return 3'h0;
        endcase
    endfunction

    // registers
    dma_cfg_t cfg_reg;
    dma_cfg_t cfg_next;
    logic req_pol_reg;
    logic bus32_reg;
    logic [31:0] rd_data_reg;
    logic [31:0] rd_data_next;
    wire [31:0] cfg_rst = `DMA_CFG_RESET;
    wire [31:0] hw_rst = `HW_MODE_RESET;

    // engine
    dma_state_t st_reg;
    dma_state_t st_next;
    dma_dir_t dir_reg;
    dma_dir_t dir_next;
    logic [2:0] bshift_reg;
    logic [23:0] words_left_reg;
    logic [23:0] words_left_next;
    logic [23:0] fetch_left_reg;
    logic [23:0] fetch_left_next;
    logic [23:0] bursts_left_reg;
    logic [23:0] bursts_left_next;
    logic [4:0] beat_left_reg;
    logic [4:0] beat_left_next;

    // pin side
    logic ack_s1_reg;
    logic ack_s2_reg;
    logic ack_s3_reg;
    logic ack_level_reg;
    logic [31:0] ext_d1_reg;
    logic [31:0] ext_d2_reg;
    logic [31:0] ext_d3_reg;
    logic request_pin_reg;
    logic ext_oe_reg;
    logic ram_rd_ready_reg;
    logic ram_wr_valid_reg;

    // fifo
    logic fifo_in_valid;
    logic [31:0] fifo_in_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [31:0] fifo_out_data;
    logic fifo_out_ready;
    logic [`FIFO_AW:0] fifo_level_next;
    logic fifo_flush;

    // register decode
    wire wr_cfg = bus.wr && bus.addr == `DMA_CFG_ADDR;
    wire wr_hw = bus.wr && bus.addr == `HW_MODE_ADDR;
    wire rd_cfg = bus.rd && bus.addr == `DMA_CFG_ADDR;
    wire rd_hw = bus.rd && bus.addr == `HW_MODE_ADDR;
    wire rd_stat = bus.rd && bus.addr == `DMA_STATUS_ADDR;
    wire new_run = bus.wdata[`CFG_RUN_BIT];
    wire start = wr_cfg && new_run && !cfg_reg.run;
    wire stop = wr_cfg && !new_run;

    // start-up sizes from the freshly written value
    // count from bits 31:8
    wire [23:0] new_count = bus.wdata[`CFG_COUNT_MSB:`CFG_COUNT_LSB];
    wire burst_cycle_select_t new_burst =
        burst_cycle_select_t'(bus.wdata[`CFG_BURST_MSB:`CFG_BURST_LSB]);
    wire dma_dir_t new_dir = dma_dir_t'(bus.wdata[`CFG_DIR_BIT]);
    wire [24:0] start_words = ceil_shift({1'b0, new_count},
                                         bus32_reg ? 3'h2 : 3'h1);
    wire [2:0] start_shift = burst_shift(new_burst);
    wire [24:0] start_bursts = ceil_shift(start_words, start_shift);

    // one beat per settled rising edge of the acknowledge pin
    wire ack_settled = ack_s2_reg == ack_s3_reg;
    wire ack_rise = ack_settled && ack_s3_reg && !ack_level_reg;
    wire beat = ack_rise && st_reg == ST_REQ &&
        (dir_reg == DIR_FROM_RAM ? fifo_out_valid : fifo_in_ready);
    wire ram_take = ram_rd_valid && ram_rd_ready_reg;
    wire ram_give = ram_wr_valid_reg && ram_wr_ready;
    wire drained = !fifo_out_valid && !ram_wr_valid_reg;
    wire done = st_reg == ST_DRAIN && drained && !stop;
    wire [4:0] blen = 5'h1 << bshift_reg;
    wire [4:0] first_beats =
        (start_words < 25'(5'h1 << start_shift)) ? 5'(start_words) :
        5'(5'h1 << start_shift);
    wire [4:0] gap_beats =
        (words_left_reg < 24'(blen)) ? 5'(words_left_reg) : blen;

    // hardware clearing of run loses to a software write
    always_comb begin
        cfg_next = cfg_reg;
        if (wr_cfg) begin
            cfg_next.byte_count = new_count;
            cfg_next.burst_cycle_select = new_burst;
            cfg_next.run = new_run;
            cfg_next.dir = new_dir;
        end else if (done) begin
            cfg_next.run = 1'b0;
        end
    end

    // engine sequencing
    always_comb begin
        st_next = st_reg;
        dir_next = dir_reg;
        words_left_next = words_left_reg;
        fetch_left_next = fetch_left_reg;
        bursts_left_next = bursts_left_reg;
        beat_left_next = beat_left_reg;
        if (ram_take && fetch_left_reg != 24'h0) begin
            fetch_left_next = fetch_left_reg - 24'h1;
        end
        case (st_reg)
            ST_IDLE: begin
                if (start) begin
                    dir_next = new_dir;
                    words_left_next = start_words[23:0];
                    bursts_left_next = start_bursts[23:0];
                    fetch_left_next = (new_dir == DIR_FROM_RAM) ?
                        start_words[23:0] : 24'h0;
                    beat_left_next = first_beats;
                    st_next = (start_words == 25'h0) ? ST_DRAIN : ST_REQ;
                end
            end
            ST_REQ: begin
                if (beat) begin
                    words_left_next = words_left_reg - 24'h1;
                    beat_left_next = beat_left_reg - 5'h1;
                    if (beat_left_reg == 5'h1) begin
                        bursts_left_next = bursts_left_reg - 24'h1;
                        st_next = (words_left_reg == 24'h1) ?
                            ST_DRAIN : ST_GAP;
                    end
                end
            end
            ST_GAP: begin
                beat_left_next = gap_beats;
                st_next = ST_REQ;
            end
            ST_DRAIN: begin
                if (drained) begin
                    st_next = ST_IDLE;
                end
            end
            default: st_next = ST_IDLE;
        endcase
        if (stop) begin
            st_next = ST_IDLE;
            words_left_next = 24'h0;
            fetch_left_next = 24'h0;
            bursts_left_next = 24'h0;
            beat_left_next = 5'h0;
        end
    end

    // request only while the fifo can follow the next beat
    wire active_next = st_next != ST_IDLE;
    wire room_next = (dir_next == DIR_FROM_RAM) ?
        fifo_level_next != '0 :
        fifo_level_next != (`FIFO_AW+1)'(`FIFO_DEPTH);
    wire req_active_next = st_next == ST_REQ && room_next;

    // fifo steering by direction
    assign fifo_flush = stop;
    assign fifo_in_valid = (dir_reg == DIR_FROM_RAM) ? ram_take :
        (beat && st_reg == ST_REQ);
    assign fifo_in_data = (dir_reg == DIR_FROM_RAM) ? ram_rd_data :
        ext_d3_reg;
    assign fifo_out_ready = (dir_reg == DIR_FROM_RAM) ? beat : ram_give;

    // read mux, reserved bits read zero
    assign rd_data_next =
        rd_cfg ? {cfg_reg.byte_count, 4'h0, cfg_reg.burst_cycle_select,
                  cfg_reg.run, cfg_reg.dir} :
        rd_hw ? {23'h0, bus32_reg, 2'h0, req_pol_reg, 5'h0} :
        rd_stat ? {bursts_left_reg, 5'h0, !fifo_out_valid, dir_reg,
                   st_reg != ST_IDLE} : 32'h0;

    dma_fifo #(
        .WIDTH(`DATA_W),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(fifo_flush),
        .in_valid(fifo_in_valid),
        .in_data(fifo_in_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_out_ready),
        .level_next(fifo_level_next)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // reserved bits 7:4 have no storage
            cfg_reg <= dma_cfg_t'({cfg_rst[`CFG_COUNT_MSB:`CFG_COUNT_LSB],
                                   cfg_rst[`CFG_BURST_MSB:0]});
            req_pol_reg <= hw_rst[`HW_REQ_POL_BIT];
            bus32_reg <= hw_rst[`HW_BUS32_BIT];
            rd_data_reg <= 32'h0;
        end else begin
            cfg_reg <= cfg_next;
            rd_data_reg <= rd_data_next;
            if (wr_hw) begin
                req_pol_reg <= bus.wdata[`HW_REQ_POL_BIT];
                bus32_reg <= bus.wdata[`HW_BUS32_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= ST_IDLE;
            dir_reg <= DIR_INTO_RAM;
            bshift_reg <= 3'h0;
            words_left_reg <= 24'h0;
            fetch_left_reg <= 24'h0;
            bursts_left_reg <= 24'h0;
            beat_left_reg <= 5'h0;
        end else begin
            st_reg <= st_next;
            dir_reg <= dir_next;
            words_left_reg <= words_left_next;
            fetch_left_reg <= fetch_left_next;
            bursts_left_reg <= bursts_left_next;
            beat_left_reg <= beat_left_next;
            if (start) begin
                bshift_reg <= start_shift;
            end
        end
    end

    // pin synchroniser: data follows the acknowledge through equal stages
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
            ack_s3_reg <= 1'b0;
            ack_level_reg <= 1'b0;
            ext_d1_reg <= 32'h0;
            ext_d2_reg <= 32'h0;
            ext_d3_reg <= 32'h0;
        end else begin
            ack_s1_reg <= dma_ack_pin;
            ack_s2_reg <= ack_s1_reg;
            ack_s3_reg <= ack_s2_reg;
            ext_d1_reg <= ext_data_in;
            ext_d2_reg <= ext_d1_reg;
            ext_d3_reg <= ext_d2_reg;
            if (ack_settled) begin
                ack_level_reg <= ack_s3_reg;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            request_pin_reg <= `REQ_PIN_RESET;
            ext_oe_reg <= 1'b0;
            ram_rd_ready_reg <= 1'b0;
            ram_wr_valid_reg <= 1'b0;
        end else begin
            request_pin_reg <= req_pol_reg ? req_active_next :
                !req_active_next;
            ext_oe_reg <= active_next && dir_next == DIR_FROM_RAM;
            ram_rd_ready_reg <= active_next && dir_next == DIR_FROM_RAM &&
                fetch_left_next != 24'h0 &&
                fifo_level_next != (`FIFO_AW+1)'(`FIFO_DEPTH);
            ram_wr_valid_reg <= active_next && dir_next == DIR_INTO_RAM &&
                fifo_level_next != '0;
        end
    end

    assign rd_data = rd_data_reg;
    assign transfer_request_pin = request_pin_reg;
    assign ext_data_out = fifo_out_data;
    assign ext_data_oe = ext_oe_reg;
    assign ram_wr_valid = ram_wr_valid_reg;
    assign ram_wr_data = fifo_out_data;
    assign ram_rd_ready = ram_rd_ready_reg;
endmodule

// file: test/host_slave_dma_config_checker.sv
// assertions on the slave dma block's register and request ports
`timescale 1ns/1ns
`include "slave_dma_regs.svh"
module host_slave_dma_config_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire slave_dma_pkg::reg_bus_t bus,
    input wire logic [31:0] rd_data,
    // external pins
    input wire logic transfer_request_pin,
    input wire logic dma_ack_pin,
    input wire logic [31:0] ext_data_in,
    input wire logic [31:0] ext_data_out,
    input wire logic ext_data_oe,
    // ram streams
    input wire logic ram_wr_valid,
    input wire logic [31:0] ram_wr_data,
    input wire logic ram_wr_ready,
    input wire logic ram_rd_valid,
    input wire logic [31:0] ram_rd_data,
    input wire logic ram_rd_ready
);
    import slave_dma_pkg::*;
    logic [31:0] cfg_reg;
    logic pol_reg;
    logic cfg_wr;
    logic mode_wr;
    assign cfg_wr = bus.wr && bus.addr == `DMA_CFG_ADDR;
    assign mode_wr = bus.wr && bus.addr == `HW_MODE_ADDR;
    // software view only; hardware clear of run is not mirrored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_reg <= `DMA_CFG_RESET;
            pol_reg <= 1'b0;
        end else begin
            if (cfg_wr)
                cfg_reg <= bus.wdata;
            if (mode_wr)
                pol_reg <= bus.wdata[`HW_REQ_POL_BIT];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_read_idle_zero: assert property (
        !$past(bus.rd) |-> rd_data == 32'h0)
        else $error("read data not zero outside answer cycle");
    a_cfg_read_back: assert property (
        $past(bus.rd && bus.addr == `DMA_CFG_ADDR) |->
        {rd_data[31:8], rd_data[7:4], rd_data[3:2], rd_data[0]} ==
        {$past(cfg_reg[31:8]), 4'h0, $past(cfg_reg[3:2]), $past(cfg_reg[0])})
        else $error("configuration read back wrong");
    a_stop_drops_req: assert property (
        cfg_wr && !bus.wdata[`CFG_RUN_BIT] |->
        ##2 transfer_request_pin == !pol_reg)
        else $error("request still active after terminate");
    a_start_raises_req: assert property (
        cfg_wr && bus.wdata[1] && !bus.wdata[0] && !cfg_reg[1] &&
        bus.wdata[31:8] != 24'h0 |-> ##[1:2] transfer_request_pin == pol_reg)
        else $error("request not raised after start");
    a_req_needs_run: assert property (
        $stable(pol_reg) && transfer_request_pin == pol_reg |->
        cfg_reg[1] || $past(cfg_reg[1]))
        else $error("request active while not enabled");
    a_oe_read_dir: assert property (
        ext_data_oe |-> cfg_reg[0] || $past(cfg_reg[0]))
        else $error("data pins driven in write direction");
    a_ram_one_dir: assert property (
        ram_wr_valid |-> !ext_data_oe && !ram_rd_ready)
        else $error("both ram directions active");
    a_fetch_read_dir: assert property (
        ram_rd_ready |-> cfg_reg[0] || $past(cfg_reg[0]))
        else $error("ram fetched in write direction");
endmodule
bind host_slave_dma_config host_slave_dma_config_checker chk (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
    .transfer_request_pin(transfer_request_pin), .dma_ack_pin(dma_ack_pin),
    .ext_data_in(ext_data_in), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe), .ram_wr_valid(ram_wr_valid),
    .ram_wr_data(ram_wr_data), .ram_wr_ready(ram_wr_ready),
    .ram_rd_valid(ram_rd_valid), .ram_rd_data(ram_rd_data),
    .ram_rd_ready(ram_rd_ready));

// file: test/ext_dma_model.sv
// model of the external dma controller answering requests beat by beat
`timescale 1ns/1ns
module ext_dma_model (
    // clock
    input wire logic clk,
    // bench control
    input wire logic pol,
    input wire logic slow,
    // block pins
    input wire logic req_pin,
    input wire logic [31:0] ext_data_out,
    input wire logic ext_data_oe,
    output logic dma_ack_pin,
    output logic [31:0] ext_data_in
);
    logic [31:0] seq;
    logic [31:0] rx_q[$];
    initial begin
        dma_ack_pin = 1'b0;
        ext_data_in = 32'h0;
        seq = 32'hA500_0000;
        forever begin
            @(posedge clk);
            if (slow && req_pin == pol)
                repeat (6) @(posedge clk);
            if (req_pin == pol) begin
                if (ext_data_oe)
                    rx_q.push_back(ext_data_out);
                dma_ack_pin <= 1'b1;
                ext_data_in <= seq;
                // long enough for the three stage sampler
                repeat (4) @(posedge clk);
                dma_ack_pin <= 1'b0;
                // released pins show the inverse, not the old word
                ext_data_in <= ~seq;
                seq <= seq + 32'h1;
                repeat (3) @(posedge clk);
            end
        end
    end
endmodule

// file: test/host_slave_dma_config_test.sv
// self-checking bench for the slave dma configuration block
`timescale 1ns/1ns
`include "slave_dma_regs.svh"
`define CHK(got, want) begin \
    tests_run++; \
    if ((got) !== (want)) begin \
        fail_count++; \
        $display("MISMATCH at %0t: got %h expected %h", $time, got, want); \
    end \
end
module host_slave_dma_config_test;
    import slave_dma_pkg::*;
    logic clk, rst_n, pol, slow;
    reg_bus_t bus;
    logic [31:0] rd_data, ext_data_in, ext_data_out, ram_wr_data, ram_rd_data;
    logic transfer_request_pin, dma_ack_pin, ext_data_oe;
    logic ram_wr_valid, ram_wr_ready, ram_rd_valid, ram_rd_ready;
    logic [31:0] sink_q[$];
    int fail_count, tests_run, src_i, src_n;

    host_slave_dma_config dut (
        .clk(clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
        .transfer_request_pin(transfer_request_pin),
        .dma_ack_pin(dma_ack_pin), .ext_data_in(ext_data_in),
        .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
        .ram_wr_valid(ram_wr_valid), .ram_wr_data(ram_wr_data),
        .ram_wr_ready(ram_wr_ready), .ram_rd_valid(ram_rd_valid),
        .ram_rd_data(ram_rd_data), .ram_rd_ready(ram_rd_ready));
    ext_dma_model far (
        .clk(clk), .pol(pol), .slow(slow), .req_pin(transfer_request_pin),
        .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
        .dma_ack_pin(dma_ack_pin), .ext_data_in(ext_data_in));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ram side: source holds each word until taken, sink collects
    always @(posedge clk) begin
        if (ram_rd_valid && ram_rd_ready)
            src_i = src_i + 1;
        ram_rd_valid <= src_i < src_n;
        ram_rd_data <= 32'hC0DE_0000 + 32'(src_i);
        if (ram_wr_valid && ram_wr_ready)
            sink_q.push_back(ram_wr_data);
    end

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(posedge clk);
        q = rd_data;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] want);
        logic [31:0] q;
        rd(a, q);
        `CHK(q, want)
    endtask
    task automatic wait_done();
        logic [31:0] q;
        q = 32'h2;
        for (int i = 0; i < 300 && q[`CFG_RUN_BIT]; i++)
            rd(`DMA_CFG_ADDR, q);
        `CHK(q[`CFG_RUN_BIT], 1'b0)
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end
    initial begin
        logic [31:0] q, base;
        int words, len;
        rst_n = 1'b0;
        bus = '0;
        pol = 1'b0;
        slow = 1'b1;
        ram_wr_ready = 1'b1;
        ram_rd_valid = 1'b0;
        ram_rd_data = 32'h0;
        src_i = 0;
        src_n = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK(transfer_request_pin, `REQ_PIN_RESET)
        rd_chk(`DMA_CFG_ADDR, `DMA_CFG_RESET);
        rd_chk(`HW_MODE_ADDR, `HW_MODE_RESET);
        rd_chk(12'h004, 32'h0);
        // every burst code on both bus widths, polarity taken from bit 0 of the code
        for (int b = 0; b < 8; b++) begin
            words = b[2] ? (40 + 3) / 4 : (40 + 1) / 2;
            len = b[1:0] == 0 ? 1 : 2 << b[1:0];
            // bursts rounded up from the words
            words = (words + len - 1) / len;
            wr(`HW_MODE_ADDR, {23'h0, b[2], 2'h0, b[0], 5'h0});
            pol <= b[0];
            // pin takes the new polarity one edge after the write lands
            @(posedge clk);
            `CHK(transfer_request_pin, ~b[0])
            wr(`DMA_CFG_ADDR, {24'd40, 4'h0, b[1:0], 2'b10});
            rd_chk(`DMA_STATUS_ADDR, {24'(words), 8'h05});
            rd_chk(`DMA_CFG_ADDR, {24'd40, 4'h0, b[1:0], 2'b10});
            wr(`DMA_CFG_ADDR, 32'h0);
            rd(`DMA_STATUS_ADDR, q);
            `CHK(q[0], 1'b0)
            `CHK(transfer_request_pin, ~b[0])
            repeat (12) @(posedge clk);
        end
        // write into ram with the ram side stalled until the fifo is full
        slow <= 1'b0;
        ram_wr_ready <= 1'b0;
        sink_q.delete();
        base = far.seq;
        wr(`DMA_CFG_ADDR, {24'd24, 8'h02});
        repeat (150) @(posedge clk);
        `CHK(sink_q.size(), 0)
        `CHK(transfer_request_pin, 1'b0)
        ram_wr_ready <= 1'b1;
        wait_done();
        `CHK(sink_q.size(), 6)
        foreach (sink_q[i]) `CHK(sink_q[i], base + 32'(i))
        // read from ram with a slow far side
        slow <= 1'b1;
        far.rx_q.delete();
        src_n <= 3;
        wr(`DMA_CFG_ADDR, {24'd12, 8'h03});
        wait_done();
        `CHK(far.rx_q.size(), 3)
        foreach (far.rx_q[i]) `CHK(far.rx_q[i], 32'hC0DE_0000 + 32'(i))
        close_out();
    end
endmodule
